// ==== inc/gpic_defs.svh ====
// constants for the input polarity and event configuration block
`ifndef GPIC_DEFS_SVH
`define GPIC_DEFS_SVH

// ==========================================================
// sizes
`define GPIC_NUM_INPUTS 19
`define GPIC_REG_W 8
`define GPIC_HIGH_W 3

// ==========================================================
// register offsets
`define GPIC_OFS_POLARITY_LOW 8'h1e
`define GPIC_OFS_POLARITY_MID 8'h1f
`define GPIC_OFS_POLARITY_HIGH 8'h20
`define GPIC_OFS_EVENT_EN_LOW 8'h21
`define GPIC_OFS_EVENT_EN_MID 8'h22
`define GPIC_OFS_EVENT_EN_HIGH 8'h23

// ==========================================================
// field positions and reset values
`define GPIC_LOW_LSB 0
`define GPIC_LOW_MSB 7
`define GPIC_MID_LSB 8
`define GPIC_MID_MSB 15
`define GPIC_HIGH_LSB 16
`define GPIC_HIGH_MSB 18
`define GPIC_CFG_RESET 19'h00000
`define GPIC_RDATA_RESET 8'h00
`define GPIC_HIGH_PAD 5'h00
`define GPIC_PRIME_RESET 3'h0

`endif

// ==== inc/gpic_pkg.sv ====
// types shared by the input polarity and event configuration block
package gpic_pkg;

   // ==========================================================
   // register port request
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } gpic_reg_req_t;

   // ==========================================================
   // event output toward the shared event queue and unlock logic
   typedef struct packed {
      logic [18:0] strobe;
      logic [18:0] active;
   } gpic_event_t;

endpackage

// ==== logic/gpic_sync.sv ====
// two flip-flop synchroniser for the asynchronous input pins
module gpic_sync #(
   parameter int WIDTH = 19
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_q;

   // ==========================================================
   // first stage is read only by the second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule

// ==== logic/gpic_top.sv ====
// per-input interrupt polarity and event enable configuration with flag and event generation
`include "gpic_defs.svh"
// What this block does
// RL1 - a cleared polarity bit makes a low input the interrupt condition, a set bit makes a high input it.
// RL2 - the first input's interrupt flag follows the row zero pin level for as long as it sits at the active level.
// RL3 - the low polarity register holds inputs one to eight in bits 0 to 7, all readable and writable.
// RL4 - the mid polarity register holds inputs nine to sixteen in bits 0 to 7, all readable and writable.
// RL5 - the high polarity register holds inputs seventeen to nineteen in bits 0 to 2, bits 7 to 3 reserved.
// RL6 - a set event enable bit makes activity on that input produce queue events, a cleared bit produces none.
// RL7 - event enable bits sit in three registers laid out like the polarity bits.
// RL8 - activity on an input in event mode raises the event interrupt indication.
// RL9 - an input in event mode never raises the input interrupt indication.
// RL10 - events from inputs in event mode go out like other queue events and also feed the unlock logic.
// RL11 - the input interrupt status is set when any input has its flag set and its interrupt enable set.
// RL12 - reserved upper bits of both high registers read as zero and ignore writes.
module gpic_top (
   input wire logic CORE_CLK,
   input wire logic RESET,
   input wire gpic_pkg::gpic_reg_req_t REG_REQ,
   output logic [7:0] REG_RDATA,
   output logic REG_RVALID,
   input wire logic [18:0] GPI_PINS,
   input wire logic [18:0] IRQ_ENABLE,
   output logic [18:0] IRQ_FLAGS,
   output logic GPI_IRQ_STATUS,
   output gpic_pkg::gpic_event_t EVENTS,
   output logic EVENT_IRQ,
   output logic [18:0] POLARITY_CFG,
   output logic [18:0] EVENT_EN_CFG
);

   // ==========================================================
   // declarations
   logic [18:0] pol_q;
   logic [18:0] pol_d;
   logic [18:0] evt_q;
   logic [18:0] evt_d;
   logic [18:0] pins_s;
   logic [18:0] prev_q;
   logic [2:0] prime_q;
   logic [18:0] level_active;
   logic [18:0] flag_d;
   logic [18:0] strobe_d;
   logic [18:0] flags_q;
   logic status_q;
   logic [18:0] strobe_q;
   logic [18:0] active_q;
   logic event_irq_q;
   logic [7:0] rdata_q;
   logic rvalid_q;
   logic wr_pol_low;
   logic wr_pol_mid;
   logic wr_pol_high;
   logic wr_evt_low;
   logic wr_evt_mid;
   logic wr_evt_high;
   logic [7:0] rd_mux;
   logic sel_pol_low;
   logic sel_pol_mid;
   logic sel_pol_high;
   logic sel_evt_low;
   logic sel_evt_mid;
   logic sel_evt_high;
   logic [7:0] pol_high_rd;
   logic [7:0] evt_high_rd;
   logic status_d;
   logic event_irq_d;
   logic [7:0] rdata_d;

   // ==========================================================
   // pin synchroniser
   gpic_sync #(
      .WIDTH(`GPIC_NUM_INPUTS)
   ) u_sync (
      .clk(CORE_CLK),
      .rst(RESET),
      .d(GPI_PINS),
      .q(pins_s)
   );

   // ==========================================================
   // address match
   assign sel_pol_low = (REG_REQ.addr == `GPIC_OFS_POLARITY_LOW);
   assign sel_pol_mid = (REG_REQ.addr == `GPIC_OFS_POLARITY_MID);
   assign sel_pol_high = (REG_REQ.addr == `GPIC_OFS_POLARITY_HIGH);
   assign sel_evt_low = (REG_REQ.addr == `GPIC_OFS_EVENT_EN_LOW);
   assign sel_evt_mid = (REG_REQ.addr == `GPIC_OFS_EVENT_EN_MID);
   assign sel_evt_high = (REG_REQ.addr == `GPIC_OFS_EVENT_EN_HIGH);

   // ==========================================================
   // write decode
   assign wr_pol_low = REG_REQ.wr && sel_pol_low;  // [RL3]
   assign wr_pol_mid = REG_REQ.wr && sel_pol_mid;  // [RL4]
   assign wr_pol_high = REG_REQ.wr && sel_pol_high;  // [RL5]
   assign wr_evt_low = REG_REQ.wr && sel_evt_low;  // [RL7]
   assign wr_evt_mid = REG_REQ.wr && sel_evt_mid;  // [RL7]
   assign wr_evt_high = REG_REQ.wr && sel_evt_high;  // [RL7]

   // upper data bits of the high registers are dropped, so reserved bits never store
   assign pol_d[`GPIC_LOW_MSB:`GPIC_LOW_LSB] =
      wr_pol_low ? REG_REQ.wdata : pol_q[`GPIC_LOW_MSB:`GPIC_LOW_LSB];  // [RL3]
   assign pol_d[`GPIC_MID_MSB:`GPIC_MID_LSB] =
      wr_pol_mid ? REG_REQ.wdata : pol_q[`GPIC_MID_MSB:`GPIC_MID_LSB];  // [RL4]
   assign pol_d[`GPIC_HIGH_MSB:`GPIC_HIGH_LSB] =
      wr_pol_high ? REG_REQ.wdata[`GPIC_HIGH_W-1:0] : pol_q[`GPIC_HIGH_MSB:`GPIC_HIGH_LSB];  // [RL5] [RL12]
   assign evt_d[`GPIC_LOW_MSB:`GPIC_LOW_LSB] =
      wr_evt_low ? REG_REQ.wdata : evt_q[`GPIC_LOW_MSB:`GPIC_LOW_LSB];  // [RL7]
   assign evt_d[`GPIC_MID_MSB:`GPIC_MID_LSB] =
      wr_evt_mid ? REG_REQ.wdata : evt_q[`GPIC_MID_MSB:`GPIC_MID_LSB];  // [RL7]
   assign evt_d[`GPIC_HIGH_MSB:`GPIC_HIGH_LSB] =
      wr_evt_high ? REG_REQ.wdata[`GPIC_HIGH_W-1:0] : evt_q[`GPIC_HIGH_MSB:`GPIC_HIGH_LSB];  // [RL7] [RL12]

   // ==========================================================
   // read decode
   // reserved upper bits are padded with zero rather than stored
   assign pol_high_rd = {`GPIC_HIGH_PAD, pol_q[`GPIC_HIGH_MSB:`GPIC_HIGH_LSB]};  // [RL5] [RL12]
   assign evt_high_rd = {`GPIC_HIGH_PAD, evt_q[`GPIC_HIGH_MSB:`GPIC_HIGH_LSB]};  // [RL7] [RL12]
   // unmapped offsets read as zero so a shared read mux can simply or the answers
   assign rd_mux =
      sel_pol_low ? pol_q[`GPIC_LOW_MSB:`GPIC_LOW_LSB] :
      sel_pol_mid ? pol_q[`GPIC_MID_MSB:`GPIC_MID_LSB] :
      sel_pol_high ? pol_high_rd :
      sel_evt_low ? evt_q[`GPIC_LOW_MSB:`GPIC_LOW_LSB] :
      sel_evt_mid ? evt_q[`GPIC_MID_MSB:`GPIC_MID_LSB] :
      sel_evt_high ? evt_high_rd :
      `GPIC_RDATA_RESET;
   // the read strobe gates the answer, so the data lines idle at zero between reads
   assign rdata_d = REG_REQ.rd ? rd_mux : `GPIC_RDATA_RESET;

   // ==========================================================
   // per-input flag and event logic
   genvar i;
   generate
      for (i = 0; i < `GPIC_NUM_INPUTS; i++) begin : g_input
         // level compare, so the flag stays up while the pin holds the active level
         assign level_active[i] = (pins_s[i] == pol_q[i]);  // [RL1] [RL2]
         // event mode takes the input out of the interrupt path entirely
         assign flag_d[i] = level_active[i] & ~evt_q[i];  // [RL9]
         // any change of the pin in event mode is one event
         assign strobe_d[i] = prime_q[2] & evt_q[i] & (pins_s[i] ^ prev_q[i]);  // [RL6]
      end
   endgenerate

   // status and event summaries
   assign status_d = |(flag_d & IRQ_ENABLE);  // [RL11] [RL9]
   assign event_irq_d = |strobe_d;  // [RL8]

   // ==========================================================
   // configuration registers
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         pol_q <= `GPIC_CFG_RESET;
         evt_q <= `GPIC_CFG_RESET;
      end else begin
         pol_q <= pol_d;
         evt_q <= evt_d;
      end
   end

   // ==========================================================
   // edge history
   // prime_q holds off events until the synchroniser and prev_q both carry real pin values,
   // so a pin that idles high through reset does not raise a false event
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         prev_q <= `GPIC_CFG_RESET;
         prime_q <= `GPIC_PRIME_RESET;
      end else begin
         prev_q <= pins_s;
         prime_q <= {prime_q[1:0], 1'b1};
      end
   end

   // ==========================================================
   // interrupt flags and status
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         flags_q <= `GPIC_CFG_RESET;
         status_q <= 1'b0;
      end else begin
         flags_q <= flag_d;  // [RL2]
         status_q <= status_d;  // [RL11] [RL9]
      end
   end

   // ==========================================================
   // events toward the queue and unlock logic
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         strobe_q <= `GPIC_CFG_RESET;
         active_q <= `GPIC_CFG_RESET;
         event_irq_q <= 1'b0;
      end else begin
         strobe_q <= strobe_d;  // [RL6] [RL10]
         active_q <= level_active;
         event_irq_q <= event_irq_d;  // [RL8]
      end
   end

   // ==========================================================
   // register read port
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         rdata_q <= `GPIC_RDATA_RESET;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= REG_REQ.rd;
      end
   end

   // ==========================================================
   // outputs
   assign REG_RDATA = rdata_q;
   assign REG_RVALID = rvalid_q;
   assign IRQ_FLAGS = flags_q;
   assign GPI_IRQ_STATUS = status_q;
   assign EVENTS.strobe = strobe_q;  // [RL10]
   assign EVENTS.active = active_q;
   assign EVENT_IRQ = event_irq_q;
   assign POLARITY_CFG = pol_q;
   assign EVENT_EN_CFG = evt_q;

endmodule

// ==== verif/gpic_top_props.sv ====
// concurrent checks on the polarity and event block ports
module gpic_top_props (
   input wire logic CORE_CLK,
   input wire logic RESET,
   input wire gpic_pkg::gpic_reg_req_t REG_REQ,
   input wire logic [7:0] REG_RDATA,
   input wire logic REG_RVALID,
   input wire logic [18:0] GPI_PINS,
   input wire logic [18:0] IRQ_ENABLE,
   input wire logic [18:0] IRQ_FLAGS,
   input wire logic GPI_IRQ_STATUS,
   input wire gpic_pkg::gpic_event_t EVENTS,
   input wire logic EVENT_IRQ,
   input wire logic [18:0] POLARITY_CFG,
   input wire logic [18:0] EVENT_EN_CFG
);
   timeunit 1ns;
   timeprecision 100ps;
   // ======
   // properties
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   a_read_answer: assert property (REG_REQ.rd |=> REG_RVALID) else $error("no answer");
   a_idle_rdata: assert property (!REG_REQ.rd |=> !REG_RVALID && REG_RDATA == 8'h00) else $error("idle");
   a_reserved_zero: assert property (REG_REQ.rd && REG_REQ.addr inside {8'h20, 8'h23} |=>
      REG_RDATA[7:3] == 5'h00) else $error("reserved");
   a_event_irq_or: assert property (EVENT_IRQ == |EVENTS.strobe) else $error("event irq");
   // one cycle of slack after a mode change, since outputs follow the config two edges after the write
   a_strobe_mode: assert property ((EVENTS.strobe & ~EVENT_EN_CFG & ~$past(EVENT_EN_CFG)) == 19'h00000)
      else $error("strobe");
   a_no_flag_evt: assert property ((IRQ_FLAGS & EVENT_EN_CFG & $past(EVENT_EN_CFG)) == 19'h00000)
      else $error("flag");
   a_flag_level: assert property (($stable(GPI_PINS) && $stable(POLARITY_CFG) && $stable(EVENT_EN_CFG))[*5]
      |-> IRQ_FLAGS == (~(GPI_PINS ^ POLARITY_CFG) & ~EVENT_EN_CFG)) else $error("level");
   a_status_any: assert property (($stable(IRQ_FLAGS) && $stable(IRQ_ENABLE))[*3]
      |-> GPI_IRQ_STATUS == |(IRQ_FLAGS & IRQ_ENABLE)) else $error("status");
   c_read: cover property (REG_REQ.rd ##1 REG_RVALID);
   c_event: cover property (EVENT_IRQ);
   c_status: cover property (GPI_IRQ_STATUS);
endmodule
bind gpic_top gpic_top_props u_props (.CORE_CLK(CORE_CLK), .RESET(RESET), .REG_REQ(REG_REQ),
   .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .GPI_PINS(GPI_PINS), .IRQ_ENABLE(IRQ_ENABLE),
   .IRQ_FLAGS(IRQ_FLAGS), .GPI_IRQ_STATUS(GPI_IRQ_STATUS), .EVENTS(EVENTS), .EVENT_IRQ(EVENT_IRQ),
   .POLARITY_CFG(POLARITY_CFG), .EVENT_EN_CFG(EVENT_EN_CFG));

// ==== verif/gpic_host.sv ====
// host model issuing one-cycle register strobes
module gpic_host (
   input wire logic clk,
   output gpic_pkg::gpic_reg_req_t req,
   input wire logic [7:0] rdata,
   input wire logic rvalid
);
   timeunit 1ns;
   timeprecision 100ps;
   // ======
   // access
   initial req = '0;
   // strobe held over exactly one edge, answer taken just after that edge
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [8:0] q);
      @(posedge clk);
      #1;
      req = '{addr: a, wr: w, rd: !w, wdata: d};
      @(posedge clk);
      #1;
      q = {rvalid, rdata};
      req = '0;
   endtask
endmodule

// ==== verif/gpic_top_test.sv ====
// self-checking bench for the polarity and event block
`include "gpic_defs.svh"
module gpic_top_test;
   timeunit 1ns;
   timeprecision 100ps;
   // ======
   // harness
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [18:0] pins = 19'h00000;
   logic [18:0] ien = 19'h00000;
   logic [31:0] lf = 32'hf930;
   int failures = 0;
   int checks_done = 0;
   int cyc = 0;
   gpic_pkg::gpic_reg_req_t req;
   gpic_pkg::gpic_event_t ev;
   logic [7:0] rd;
   logic rv, st, eirq;
   logic [18:0] fl, pc, ec;
   always #2.5 clk = ~clk;
   gpic_top dut (.CORE_CLK(clk), .RESET(rst), .REG_REQ(req), .REG_RDATA(rd), .REG_RVALID(rv), .GPI_PINS(pins),
      .IRQ_ENABLE(ien), .IRQ_FLAGS(fl), .GPI_IRQ_STATUS(st), .EVENTS(ev), .EVENT_IRQ(eirq), .POLARITY_CFG(pc),
      .EVENT_EN_CFG(ec));
   gpic_host host (.clk(clk), .req(req), .rdata(rd), .rvalid(rv));
   function automatic logic [18:0] rnd();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf[18:0];
   endfunction
   function automatic logic [7:0] fld(input logic [18:0] v, input int k);
      return (k == 2) ? {5'h00, v[18:16]} : v[k * 8 +: 8];
   endfunction
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic final_report();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // index 6 lands on the first unmapped offset
   task automatic wr(input int k, input logic [7:0] d);
      logic [8:0] q;
      host.access(1'b1, `GPIC_OFS_POLARITY_LOW + 8'(k), d, q);
   endtask
   task automatic rdk(input int k, input logic [7:0] e);
      logic [8:0] q;
      host.access(1'b0, `GPIC_OFS_POLARITY_LOW + 8'(k), 8'h00, q);
      check("read", q, {1'b1, e});
   endtask
   task automatic cfg(input logic [18:0] p, input logic [18:0] e);
      for (int k = 0; k < 3; k++) begin
         wr(k, fld(p, k));
         wr(k + 3, fld(e, k));
      end
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         failures++;
         final_report();
      end
   end
   // ======
   // scenarios
   initial begin
      logic [18:0] p, e, o;
      logic [7:0] d;
      int j;
      tick(6);
      rst = 1'b0;
      for (int k = 0; k < 7; k++) rdk(k, 8'h00);
      for (int k = 0; k < 21; k++) begin
         j = k % 7;
         d = 8'(rnd());
         wr(j, d);
         rdk(j, j == 6 ? 8'h00 : j % 3 == 2 ? d & 8'h07 : d);
      end
      for (int k = 0; k < 6; k++) begin
         p = k == 0 ? 19'h00000 : rnd();
         cfg(p, 19'h00000);
         pins = rnd();
         ien = rnd();
         tick(5);
         check("pol", pc, p);
         check("flags", fl, {~(pins ^ p)});
         check("status", st, |(~(pins ^ p) & ien));
      end
      for (int k = 0; k < 6; k++) begin
         e = k == 0 ? 19'h7ffff : rnd();
         cfg(p, e);
         tick(3);
         o = pins;
         pins = rnd();
         tick(3);
         check("evtcfg", ec, e);
         check("strobe", ev.strobe, {(o ^ pins) & e});
         check("active", ev.active & ev.strobe, {~(pins ^ p) & (o ^ pins) & e});
         check("eirq", eirq, |((o ^ pins) & e));
         check("flags", fl, {~(pins ^ p) & ~e});
         tick(1);
         check("pulse", eirq, 1'b0);
      end
      // mid-run reset with every pin held high, as pulled-up inputs idle; no event may follow release
      pins = 19'h7ffff;
      tick(3);
      rst = 1'b1;
      tick(6);
      rst = 1'b0;
      check("rstpol", pc, 19'h00000);
      check("rstevt", ec, 19'h00000);
      wr(3, 8'hff);
      tick(1);
      check("rststrobe", ev.strobe, 19'h00000);
      check("rsteirq", eirq, 1'b0);
      tick(2);
      check("rststrobe", ev.strobe, 19'h00000);
      rdk(3, 8'hff);
      final_report();
   end
endmodule
